/* File: iof_formatter.sv */
// IMU output formatter: gyro units, delay, g-compensation, accel scaling, APB
`timescale 1ns/1ps
module iof_formatter import iof_pkg::*; #(
  parameter int SMP_CYCLES    = SMP_CYC,
  parameter int DLY_SAMPLES   = DLY_SMP,
  parameter int RATE_LOG2_MAX = RLOG_MAX
) (
  // Clock and reset
  input  wire logic                    mclk,
  input  wire logic                    reset_n,
  // APB slave
  input  wire logic                    psel,
  input  wire logic                    penable,
  input  wire logic                    pwrite,
  input  wire logic [7:0]              paddr,
  input  wire logic [31:0]             pwdata,
  output logic [31:0]                  prdata,
  output logic                         pready,
  output logic                         pslverr,
  // Raw sensor samples
  input  wire logic signed [W-1:0]     gyro_in,
  input  wire logic signed [ACC_W-1:0] accel_in,
  input  wire logic signed [ACC_W-1:0] incl_in,
  // Formatted words and byte stream
  output logic                         tx_vld,
  output iof_word_t                    gyro_word,
  output iof_word_t                    accel_word,
  output logic                         byte_vld,
  output logic                         byte_first,
  output logic [7:0]                   byte_data
);

  localparam int SCW  = $clog2(SMP_CYCLES);
  localparam int CW   = RATE_LOG2_MAX;
  localparam int SUMW = W + RATE_LOG2_MAX;

  if (SMP_CYCLES < 16 || DLY_SAMPLES < 1 || RATE_LOG2_MAX < 1 || RATE_LOG2_MAX > 7) begin : g_chk
    $error("iof_formatter: unsupported parameter value");
  end

  iof_ctrl_t                ctrl_r;
  logic [2:0]               rlog_r;
  logic signed [15:0]       cbias_r;
  logic signed [15:0]       csf_r;
  logic [7:0]               tx_cnt_r;
  logic [SCW-1:0]           smp_cnt_r;
  logic                     smp_tick_r;
  logic signed [W-1:0]      gyro_f;
  logic signed [ACC_W-1:0]  acc_f;
  logic                     g_vld;
  logic [LPF_SHW-1:0]       comp_sh;
  logic signed [ACC_W+15:0] bprod;
  logic signed [ACC_W+15:0] kprod;
  logic signed [W-1:0]      kfac;
  logic signed [2*W-1:0]    sprod;
  logic signed [W-1:0]      rate_c;
  logic signed [W-1:0]      rate_use;
  logic signed [W-1:0]      dly_mem [DLY_SAMPLES];
  logic                     dly_en;
  logic [CW-1:0]            pos_cnt_r;
  logic [CW-1:0]            n_last;
  logic                     last_smp;
  logic signed [SUMW-1:0]   sum_r;
  logic signed [SUMW-1:0]   sum_nxt;
  logic signed [SUMW+15:0]  iprod;
  logic signed [INT_W-1:0]  inc_step;
  logic signed [INT_W-1:0]  int_acc_r;
  logic signed [INT_W-1:0]  int_nxt;
  logic signed [W-1:0]      gyro_nxt;
  logic signed [ACC_W-1:0]  acc_sh;
  logic signed [W-1:0]      accel_nxt;
  logic [47:0]              shreg_r;
  logic [2:0]               bcnt_r;
  logic                     rate_sign_bit;
  logic [7:0]               rate_msb_byte;
  logic [7:0]               accel_msb_byte;
  logic                     setup;
  logic                     wr_acc;
  logic                     bad_rate;

  // APB phase decode; the slave answers in the first access cycle
  assign setup    = psel & ~penable;
  assign wr_acc   = psel & penable & pwrite;
  assign bad_rate = pwdata[2:0] > 3'(RATE_LOG2_MAX);

  // Register writes; illegal rate values are refused
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      ctrl_r  <= CTRL_RST;
      rlog_r  <= RATE_RST;
      cbias_r <= COEF_RST;
      csf_r   <= COEF_RST;
    end else if (wr_acc) begin
      if (paddr == REG_CTRL) begin
        ctrl_r <= pwdata[15:0];
      end else if (paddr == REG_RATE && !bad_rate) begin
        rlog_r <= pwdata[2:0];
      end else if (paddr == REG_CBIAS) begin
        cbias_r <= pwdata[15:0];
      end else if (paddr == REG_CSF) begin
        csf_r <= pwdata[15:0];
      end
    end
  end

  // Read data and error flag prepared in the setup cycle
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      prdata  <= 32'h0;
      pslverr <= 1'b0;
      pready  <= 1'b0;
    end else begin
      pready <= 1'b1;
      if (setup) begin
        pslverr <= 1'b0;
        prdata  <= 32'h0;
        if (paddr == REG_CTRL) begin
          prdata <= {16'h0, ctrl_r};
        end else if (paddr == REG_RATE) begin
          prdata  <= {29'h0, rlog_r};
          pslverr <= pwrite & bad_rate;
        end else if (paddr == REG_CBIAS) begin
          prdata <= {16'h0, cbias_r};
        end else if (paddr == REG_CSF) begin
          prdata <= {16'h0, csf_r};
        end else if (paddr == REG_STAT) begin
          prdata <= {tx_cnt_r, gyro_word};
        end else begin
          pslverr <= 1'b1;
        end
      end
    end
  end

  // Internal sample tick at 2000 per second
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      smp_cnt_r  <= '0;
      smp_tick_r <= 1'b0;
    end else begin
      smp_tick_r <= smp_cnt_r == SCW'(SMP_CYCLES - 1);
      if (smp_cnt_r == SCW'(SMP_CYCLES - 1)) begin
        smp_cnt_r <= '0;
      end else begin
        smp_cnt_r <= smp_cnt_r + 1'b1;
      end
    end
  end

  // Gyro low-pass ahead of every unit, averaging included
  iof_lpf #(.WD(W), .SHW(LPF_SHW)) u_gyro_lpf (
    .mclk    (mclk),
    .reset_n (reset_n),
    .in_vld  (smp_tick_r),
    .x       (gyro_in),
    .shift   (ctrl_r.gyro_lpf),
    .y       (gyro_f),
    .out_vld (g_vld)
  );

  // Corner select for the compensation filter
  always_comb begin
    case (ctrl_r.comp_lpf)
      CLPF_5HZ:   comp_sh = SHIFT_5HZ;
      CLPF_10MHZ: comp_sh = SHIFT_10MHZ;
      CLPF_1MHZ:  comp_sh = SHIFT_1MHZ;
      default:    comp_sh = '0;
    endcase
  end

  // Accel or incl signal filtered before use in compensation
  iof_lpf #(.WD(ACC_W), .SHW(LPF_SHW)) u_comp_lpf (
    .mclk    (mclk),
    .reset_n (reset_n),
    .in_vld  (smp_tick_r),
    .x       (ctrl_r.comp_src ? incl_in : accel_in),
    .shift   (comp_sh),
    .y       (acc_f),
    .out_vld ()
  );

  // Bias and scale-factor g-compensation
  always_comb begin
    bprod  = acc_f * cbias_r;
    kprod  = acc_f * csf_r;
    kfac   = W'(kprod >>> ACC_FRAC);
    sprod  = gyro_f * kfac;
    rate_c = gyro_f;
    if (ctrl_r.comp_mode[0]) begin
      rate_c = rate_c - W'(bprod >>> ACC_FRAC);
    end
    if (ctrl_r.comp_mode[1]) begin
      rate_c = rate_c + W'(sprod >>> W);
    end
  end

  // Gyro delay line of DLY_SAMPLES internal samples
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      for (int i = 0; i < DLY_SAMPLES; i++) begin
        dly_mem[i] <= '0;
      end
    end else if (g_vld) begin
      dly_mem[0] <= rate_c;
      for (int i = 1; i < DLY_SAMPLES; i++) begin
        dly_mem[i] <= dly_mem[i-1];
      end
    end
  end

  assign dly_en   = ctrl_r.gyro_unit >= UNIT_DLY_MIN;
  assign rate_use = dly_en ? dly_mem[DLY_SAMPLES-1] : rate_c;

  // Interval bookkeeping and unit arithmetic
  always_comb begin
    n_last    = CW'((1 << rlog_r) - 1);
    last_smp  = pos_cnt_r >= n_last;
    sum_nxt   = sum_r + SUMW'(rate_use);
    iprod     = sum_nxt * 16'(INC_GAIN);
    inc_step  = rate_use * 16'(INC_GAIN);
    int_nxt   = int_acc_r + inc_step;
    case (ctrl_r.gyro_unit[2:0])
      UNIT_INCR: gyro_nxt = W'(iprod >>> INC_FRAC);
      UNIT_AVG:  gyro_nxt = W'(sum_nxt >>> rlog_r);
      UNIT_INTG: gyro_nxt = int_nxt[INT_W-1:INC_FRAC];
      default:   gyro_nxt = rate_use;
    endcase
  end

  // Accel scaling per range, saturated to 24 bits
  always_comb begin
    case (ctrl_r.acc_range)
      RNG_10G: acc_sh = accel_in >>> SH_10G;
      RNG_30G: acc_sh = accel_in >>> SH_30G;
      RNG_80G: acc_sh = accel_in >>> SH_80G;
      default: acc_sh = accel_in >>> SH_5G;
    endcase
    if (acc_sh > $signed(ACC_W'({1'b0, {(W-1){1'b1}}}))) begin
      accel_nxt = {1'b0, {(W-1){1'b1}}};
    end else if (acc_sh < $signed(ACC_W'(-(2 ** (W-1))))) begin
      accel_nxt = {1'b1, {(W-1){1'b0}}};
    end else begin
      accel_nxt = acc_sh[W-1:0];
    end
  end

  // Sums restart each interval; the integrated angle runs on and wraps
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      sum_r     <= '0;
      pos_cnt_r <= '0;
      int_acc_r <= '0;
    end else if (g_vld) begin
      int_acc_r <= int_nxt;
      if (last_smp) begin
        sum_r     <= '0;
        pos_cnt_r <= '0;
      end else begin
        sum_r     <= sum_nxt;
        pos_cnt_r <= pos_cnt_r + 1'b1;
      end
    end
  end

  // Output words at the end of each interval
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      tx_vld     <= 1'b0;
      gyro_word  <= '0;
      accel_word <= '0;
      tx_cnt_r   <= '0;
    end else begin
      tx_vld <= g_vld & last_smp;
      if (g_vld && last_smp) begin
        gyro_word  <= gyro_nxt;
        accel_word <= accel_nxt;
        tx_cnt_r   <= tx_cnt_r + 1'b1;
      end
    end
  end

  // Byte stream, gyro word then accel word, most significant byte first
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      shreg_r    <= '0;
      bcnt_r     <= '0;
      byte_vld   <= 1'b0;
      byte_first <= 1'b0;
      byte_data  <= 8'h00;
    end else begin
      byte_vld   <= 1'b0;
      byte_first <= 1'b0;
      if (g_vld && last_smp) begin
        shreg_r <= {gyro_nxt, accel_nxt};
        bcnt_r  <= 3'h6;
      end else if (bcnt_r != 3'h0) begin
        byte_vld   <= 1'b1;
        byte_first <= bcnt_r == 3'h6;
        byte_data  <= shreg_r[47:40];
        shreg_r    <= {shreg_r[39:0], 8'h00};
        bcnt_r     <= bcnt_r - 1'b1;
      end
    end
  end

  assign rate_sign_bit  = gyro_word.msb[7];
  assign rate_msb_byte  = gyro_word.msb;
  assign accel_msb_byte = accel_word.msb;

  // Checks
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!reset_n);

  property p_dly;
    g_vld && last_smp && ctrl_r.gyro_unit == UNIT_DLY_MIN
      |=> $signed(gyro_word) == $past(dly_mem[DLY_SAMPLES-1]) && dly_mem[0] == $past(rate_c);
  endproperty
  a_dly: assert property (p_dly) else $error("delayed gyro sample not used");

  property p_bytes;
    tx_vld |=> byte_first && byte_data == rate_msb_byte ##1 byte_vld && byte_data == gyro_word.mid
      ##1 byte_data == gyro_word.lsb ##1 byte_data == accel_msb_byte;
  endproperty
  a_bytes: assert property (p_bytes) else $error("byte order wrong");

  property p_sign;
    tx_vld |-> rate_sign_bit == $past(gyro_nxt[W-1]) && accel_word.msb[7] == $past(acc_sh[ACC_W-1]);
  endproperty
  a_sign: assert property (p_sign) else $error("sign bit mismatch");

  property p_rate;
    g_vld && last_smp && ctrl_r.gyro_unit == 4'h0 |=> $signed(gyro_word) == $past(rate_c);
  endproperty
  a_rate: assert property (p_rate) else $error("rate word mismatch");

  property p_avg1;
    g_vld && last_smp && ctrl_r.gyro_unit == 4'h2 && rlog_r == 3'h0 |=> $signed(gyro_word) == $past(rate_c);
  endproperty
  a_avg1: assert property (p_avg1) else $error("single-sample average wrong");

  property p_int_hold;
    !g_vld |=> $stable(int_acc_r);
  endproperty
  a_int_hold: assert property (p_int_hold) else $error("integrator moved without sample");

  property p_restart;
    g_vld && last_smp |=> sum_r == '0 && pos_cnt_r == '0 && tx_vld;
  endproperty
  a_restart: assert property (p_restart) else $error("interval did not restart");

  property p_tick;
    smp_tick_r |=> !smp_tick_r [*8];
  endproperty
  a_tick: assert property (p_tick) else $error("sample tick too close");

  property p_lpf_lat;
    smp_tick_r |=> g_vld ##1 !g_vld;
  endproperty
  a_lpf_lat: assert property (p_lpf_lat) else $error("filtered sample late");

  property p_acc80;
    g_vld && last_smp && ctrl_r.acc_range == RNG_80G
      |=> accel_word == $past(accel_in[W-1+SH_80G:SH_80G]);
  endproperty
  a_acc80: assert property (p_acc80) else $error("80g scaling wrong");

  c_avg:  cover property (tx_vld && ctrl_r.gyro_unit[2:0] == UNIT_AVG && rlog_r == 3'h2);
  c_wrap: cover property (g_vld && int_acc_r[INT_W-1] != int_nxt[INT_W-1]);
  c_dly:  cover property (tx_vld && dly_en);
  c_comp: cover property (tx_vld && ctrl_r.comp_mode == 2'h3);

endmodule

/* File: iof_host_model.sv */
// Host model: rebuilds output words from the formatter byte stream
`timescale 1ns/1ps
module iof_host_model import iof_pkg::*; (
  // Clock and reset
  input  wire logic       mclk,
  input  wire logic       reset_n,
  // Byte stream
  input  wire logic       byte_vld,
  input  wire logic       byte_first,
  input  wire logic [7:0] byte_data,
  // Rebuilt words and signed values
  output iof_word_t       gyro_raw,
  output iof_word_t       accel_raw,
  output int              gyro_val,
  output int              accel_val
);
  logic [7:0] buf_r [6];
  int         idx_r;
  int         k;

  // Slot of the incoming byte
  assign k = byte_first ? 0 : idx_r;

  // Collect six bytes, most significant byte of each word first
  always @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      idx_r     <= 0;
      gyro_raw  <= '0;
      accel_raw <= '0;
    end else if (byte_vld) begin
      buf_r[k] <= byte_data;
      idx_r    <= k + 1;
      if (k == 5) begin
        gyro_raw  <= {buf_r[0], buf_r[1], buf_r[2]};
        accel_raw <= {buf_r[3], buf_r[4], byte_data};
      end
    end
  end

  // Top bit weighs minus 2^24 against the unsigned sum
  always_comb begin
    gyro_val  = int'({8'h00, gyro_raw}) - int'(gyro_raw.msb[7]) * (1 << 24);
    accel_val = int'({8'h00, accel_raw}) - int'(accel_raw.msb[7]) * (1 << 24);
  end
endmodule

/* File: iof_lpf.sv */
// One-pole low-pass filter with a shift-selected corner
`timescale 1ns/1ps
module iof_lpf #(
  parameter int WD  = 28,
  parameter int SHW = 5
) (
  // Clock and reset
  input  wire logic                 mclk,
  input  wire logic                 reset_n,
  // Sample in
  input  wire logic                 in_vld,
  input  wire logic signed [WD-1:0] x,
  input  wire logic [SHW-1:0]       shift,
  // Filtered sample out
  output logic signed [WD-1:0]      y,
  output logic                      out_vld
);

  localparam int FR = (2 ** SHW) - 1;
  localparam int SW = WD + FR;

  logic signed [SW-1:0] s_r;
  logic signed [SW:0]   diff;
  logic signed [SW:0]   step;

  if (WD < 2 || SHW < 1 || SHW > 5) begin : g_chk
    $error("iof_lpf: unsupported width or shift width");
  end

  // Input minus state, kept one bit wider
  always_comb begin
    diff = $signed({x[WD-1], x, {FR{1'b0}}}) - $signed({s_r[SW-1], s_r});
    step = diff >>> shift;
  end

  // State update; shift 0 passes the input straight through
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      s_r     <= '0;
      out_vld <= 1'b0;
    end else begin
      out_vld <= in_vld;
      if (in_vld) begin
        if (shift == '0) begin
          s_r <= {x, {FR{1'b0}}};
        end else begin
          s_r <= s_r + step[SW-1:0];
        end
      end
    end
  end

  assign y = s_r[SW-1:FR];

endmodule

/* File: iof_pkg.sv */
// Constants, types and register map for the IMU output formatter
package iof_pkg;

  // Timing
  localparam int CLK_HZ      = 10_000_000;
  localparam int SMP_HZ      = 2000;
  localparam int SMP_CYC     = CLK_HZ / SMP_HZ;
  localparam int DLY_US      = 4500;
  localparam int DLY_SMP     = DLY_US * SMP_HZ / 1_000_000;

  // Data widths and fixed-point scaling
  localparam int W           = 24;
  localparam int ACC_W       = 28;
  localparam int ACC_FRAC    = 20;
  localparam int RATE_FRAC   = 14;
  localparam int ANGLE_FRAC  = 21;
  localparam int INC_FRAC    = 16;
  localparam int INC_GAIN    = (2 ** (INC_FRAC + ANGLE_FRAC - RATE_FRAC)) / SMP_HZ;
  localparam int INT_W       = W + 16;
  localparam int RLOG_MAX    = 4;
  localparam int LPF_SHW     = 5;

  // Gyro output unit codes, low three bits; bit 3 selects the delay
  localparam logic [3:0] UNIT_DLY_MIN = 4'h8;
  localparam logic [2:0] UNIT_RATE    = 3'h0;
  localparam logic [2:0] UNIT_INCR    = 3'h1;
  localparam logic [2:0] UNIT_AVG     = 3'h2;
  localparam logic [2:0] UNIT_INTG    = 3'h3;

  // Acceleration range codes and their right shifts from 2^20 LSB per g
  localparam logic [1:0] RNG_5G      = 2'h0;
  localparam logic [1:0] RNG_10G     = 2'h1;
  localparam logic [1:0] RNG_30G     = 2'h2;
  localparam logic [1:0] RNG_80G     = 2'h3;
  localparam int         SH_5G       = 0;
  localparam int         SH_10G      = 1;
  localparam int         SH_30G      = 2;
  localparam int         SH_80G      = 4;

  // Compensation filter corners as shift of a one-pole filter at 2000 Hz
  localparam logic [1:0]         CLPF_OFF    = 2'h0;
  localparam logic [1:0]         CLPF_5HZ    = 2'h1;
  localparam logic [1:0]         CLPF_10MHZ  = 2'h2;
  localparam logic [1:0]         CLPF_1MHZ   = 2'h3;
  localparam logic [LPF_SHW-1:0] SHIFT_5HZ   = 5'h06;
  localparam logic [LPF_SHW-1:0] SHIFT_10MHZ = 5'h0f;
  localparam logic [LPF_SHW-1:0] SHIFT_1MHZ  = 5'h12;

  // Register map, byte addresses
  localparam logic [7:0] REG_CTRL  = 8'h00;
  localparam logic [7:0] REG_RATE  = 8'h04;
  localparam logic [7:0] REG_CBIAS = 8'h08;
  localparam logic [7:0] REG_CSF   = 8'h0c;
  localparam logic [7:0] REG_STAT  = 8'h10;

  // Control register layout, bits 15..0
  typedef struct packed {
    logic [1:0]         comp_lpf;
    logic               comp_src;
    logic [1:0]         comp_mode;
    logic [1:0]         acc_range;
    logic [LPF_SHW-1:0] gyro_lpf;
    logic [3:0]         gyro_unit;
  } iof_ctrl_t;

  localparam logic [15:0] CTRL_RST  = 16'h0000;
  localparam logic [2:0]  RATE_RST  = 3'h2;
  localparam logic [15:0] COEF_RST  = 16'h0000;

  // One output word, most significant byte first
  typedef struct packed {
    logic [7:0] msb;
    logic [7:0] mid;
    logic [7:0] lsb;
  } iof_word_t;

endpackage

/* File: testbench.sv */
// Testbench for the IMU output formatter
`timescale 1ns/1ps
module testbench import iof_pkg::*;;
  localparam int          SMP  = 40;
  localparam logic [23:0] G    = 24'h100000;
  localparam logic [23:0] G2   = 24'h200000;
  localparam logic [23:0] GN   = 24'hedcbaa;
  localparam logic [23:0] INC4 = 24'h041880;
  localparam logic [23:0] STEP = 24'h010620;
  localparam logic [27:0] ONE_G = 28'h0100000;

  logic                    mclk;
  logic                    reset_n;
  logic                    psel;
  logic                    penable;
  logic                    pwrite;
  logic [7:0]              paddr;
  logic [31:0]             pwdata;
  logic [31:0]             prdata;
  logic                    pready;
  logic                    pslverr;
  logic signed [W-1:0]     gyro_in;
  logic signed [ACC_W-1:0] accel_in;
  logic signed [ACC_W-1:0] incl_in;
  logic                    tx_vld;
  iof_word_t               gyro_word;
  iof_word_t               accel_word;
  logic                    byte_vld;
  logic                    byte_first;
  logic [7:0]              byte_data;
  iof_word_t               h_gyro;
  iof_word_t               h_accel;
  int                      h_gv;
  int                      h_av;
  int                      n_errors;
  int                      n_tests;
  int                      gap;
  logic [31:0]             rd;
  logic                    err;
  logic [23:0]             prev;
  logic                    wrapped;
  logic [23:0]             acc_exp [4] = '{24'hd00000, 24'he80000, 24'hf40000, 24'hfd0000};

  iof_formatter #(.SMP_CYCLES(SMP)) u_iof_formatter (
    .mclk(mclk), .reset_n(reset_n), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .gyro_in(gyro_in), .accel_in(accel_in), .incl_in(incl_in), .tx_vld(tx_vld),
    .gyro_word(gyro_word), .accel_word(accel_word), .byte_vld(byte_vld),
    .byte_first(byte_first), .byte_data(byte_data)
  );

  iof_host_model u_iof_host_model (
    .mclk(mclk), .reset_n(reset_n), .byte_vld(byte_vld), .byte_first(byte_first),
    .byte_data(byte_data), .gyro_raw(h_gyro), .accel_raw(h_accel), .gyro_val(h_gv), .accel_val(h_av)
  );

  // Clock generation
  initial begin
    mclk = 1'b0;
    forever #50 mclk = ~mclk;
  end

  // Compare and count
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      n_errors++;
      $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // One APB transfer, held until pready is sampled high
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge mclk);
    penable <= 1'b1;
    do begin
      @(posedge mclk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  // Wait for n output words, recording the spacing of the last
  task automatic wait_tx(input int n);
    int k;
    for (int i = 0; i < n; i++) begin
      k = 0;
      do begin
        @(posedge mclk);
        k++;
      end while (tx_vld !== 1'b1 && k < 2000);
      gap = k;
      if (tx_vld !== 1'b1) chk(32'h0, 32'h1);
    end
  endtask

  // Control word builder
  function automatic logic [31:0] cw(input logic [3:0] u, input logic [1:0] rng, input logic [1:0] cm,
                                     input logic cs, input logic [1:0] cl);
    iof_ctrl_t c;
    c = '{comp_lpf: cl, comp_src: cs, comp_mode: cm, acc_range: rng, gyro_lpf: 5'h00, gyro_unit: u};
    return {16'h0000, c};
  endfunction

  // Counts, verdict and end of run
  task automatic test_done;
    $display("Comparisons %0d, mismatches %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask

  // Watchdog against a hang
  initial begin
    repeat (90000) @(posedge mclk);
    n_errors = n_errors + 1;
    test_done;
  end

  // Main sequence
  initial begin
    n_errors = 0;
    n_tests  = 0;
    reset_n  = 1'b0;
    psel     = 1'b0;
    penable  = 1'b0;
    pwrite   = 1'b0;
    paddr    = 8'h00;
    pwdata   = 32'h0;
    gyro_in  = G;
    accel_in = 28'h0;
    incl_in  = 28'h0;
    repeat (5) @(posedge mclk);
    reset_n <= 1'b1;
    // Register reset values and refused accesses
    apb(1'b0, REG_CTRL, 32'h0);
    chk(rd, {16'h0000, CTRL_RST});
    apb(1'b0, REG_CBIAS, 32'h0);
    chk(rd, 32'h0);
    apb(1'b0, 8'h14, 32'h0);
    chk({31'h0, err}, 32'h1);
    chk(rd, 32'h0);
    apb(1'b1, REG_RATE, 32'h5);
    chk({31'h0, err}, 32'h1);
    apb(1'b0, REG_RATE, 32'h0);
    chk(rd, 32'h2);
    // Rate mode with a negative value, then the byte stream
    apb(1'b1, REG_RATE, 32'h0);
    gyro_in <= GN;
    wait_tx(3);
    chk(gyro_word, GN);
    wait_tx(1);
    chk(gap, SMP);
    repeat (10) @(posedge mclk);
    chk(h_gyro, GN);
    chk(32'(h_gv), 32'hffedcbaa);
    apb(1'b0, REG_STAT, 32'h0);
    chk(rd[23:0], GN);
    // Acceleration scaling for every range
    for (int r = 0; r < 4; r++) begin
      apb(1'b1, REG_CTRL, cw(4'h0, 2'(r), 2'h0, 1'b0, 2'h0));
      accel_in <= 28'hfd00000;
      wait_tx(2);
      chk(accel_word, acc_exp[r]);
    end
    repeat (10) @(posedge mclk);
    chk(32'(h_av), 32'hfffd0000);
    chk(h_accel, 24'hfd0000);
    apb(1'b1, REG_CTRL, cw(4'h0, 2'h0, 2'h0, 1'b0, 2'h0));
    accel_in <= 28'h0800000;
    wait_tx(2);
    chk(accel_word, 24'h7fffff);
    // Incremental angle over four samples, restarting each interval
    gyro_in <= G;
    apb(1'b1, REG_CTRL, cw(4'h1, 2'h0, 2'h0, 1'b0, 2'h0));
    apb(1'b1, REG_RATE, 32'h2);
    wait_tx(2);
    chk(gyro_word, INC4);
    wait_tx(1);
    chk(gyro_word, INC4);
    chk(gap, 4 * SMP);
    // Average with a step after two samples of the interval
    apb(1'b1, REG_CTRL, cw(4'h2, 2'h0, 2'h0, 1'b0, 2'h0));
    wait_tx(2);
    chk(gyro_word, G);
    repeat (80) @(posedge mclk);
    gyro_in <= G2;
    wait_tx(1);
    chk(gyro_word, 24'h180000);
    // Average of a single sample per transmission
    apb(1'b1, REG_RATE, 32'h0);
    wait_tx(2);
    chk(gyro_word, G2);
    // Gyro filter at shift 1 halves a step down to G before averaging
    gyro_in <= G;
    apb(1'b1, REG_CTRL, 32'h00000012);
    wait_tx(1);
    chk(gyro_word, 24'h180000);
    wait_tx(1);
    chk(gyro_word, 24'h140000);
    // Delayed rate output holds the old value for nine samples
    apb(1'b1, REG_CTRL, cw(4'h8, 2'h0, 2'h0, 1'b0, 2'h0));
    gyro_in <= G;
    wait_tx(12);
    gyro_in <= G2;
    wait_tx(9);
    chk(gyro_word, G);
    wait_tx(1);
    chk(gyro_word, G2);
    // Bias and scale compensation from each source
    gyro_in <= G;
    accel_in <= ONE_G;
    incl_in <= 28'h0200000;
    apb(1'b1, REG_CBIAS, 32'h100);
    apb(1'b1, REG_CSF, 32'h1000);
    apb(1'b1, REG_CTRL, cw(4'h0, 2'h0, 2'h1, 1'b0, 2'h0));
    wait_tx(3);
    chk(gyro_word, 24'h0fff00);
    apb(1'b1, REG_CTRL, cw(4'h0, 2'h0, 2'h1, 1'b1, 2'h0));
    wait_tx(3);
    chk(gyro_word, 24'h0ffe00);
    apb(1'b1, REG_CTRL, cw(4'h0, 2'h0, 2'h2, 1'b0, 2'h0));
    wait_tx(3);
    chk(gyro_word, 24'h100100);
    apb(1'b1, REG_CSF, 32'h2000);
    apb(1'b1, REG_CTRL, cw(4'h0, 2'h0, 2'h3, 1'b1, 2'h0));
    wait_tx(3);
    chk(gyro_word, 24'h100200);
    // Slow source filter hides a fresh step
    accel_in <= 28'h0;
    apb(1'b1, REG_CTRL, cw(4'h0, 2'h0, 2'h1, 1'b0, 2'h0));
    wait_tx(3);
    chk(gyro_word, G);
    apb(1'b1, REG_CTRL, cw(4'h0, 2'h0, 2'h1, 1'b0, 2'h3));
    accel_in <= ONE_G;
    wait_tx(3);
    chk(gyro_word, G);
    // Integrated angle steps by one increment and wraps
    apb(1'b1, REG_CTRL, cw(4'h3, 2'h0, 2'h0, 1'b0, 2'h0));
    wait_tx(2);
    prev = gyro_word;
    wrapped = 1'b0;
    repeat (260) begin
      wait_tx(1);
      chk({8'h00, 24'(gyro_word - prev)}, {8'h00, STEP});
      if (gyro_word[23] && !prev[23]) wrapped = 1'b1;
      prev = gyro_word;
    end
    chk({31'h0, wrapped}, 32'h1);
    // Second reset restarts the integrator from zero
    @(posedge mclk);
    reset_n <= 1'b0;
    repeat (5) @(posedge mclk);
    reset_n <= 1'b1;
    apb(1'b1, REG_CTRL, cw(4'h3, 2'h0, 2'h0, 1'b0, 2'h0));
    wait_tx(1);
    chk(gyro_word, INC4);
    test_done;
  end
endmodule
